// >>> hdl/fdg_consts.svh
// constants for the floppy controller glue block
`ifndef FDG_CONSTS_SVH
`define FDG_CONSTS_SVH

// ===========================================================
// register byte offsets
`define FDG_OFS_CTRL 8'h00
`define FDG_OFS_STAT 8'h04
`define FDG_OFS_IRQ_STAT 8'h08
`define FDG_OFS_IRQ_MASK 8'h0C

// ===========================================================
// control register fields
`define FDG_CTRL_WAIT_EN 0
`define FDG_CTRL_PRECOMP 1
`define FDG_CTRL_SIDE 2
`define FDG_CTRL_ALT_MODE 3
`define FDG_CTRL_DOUBLE_DENSITY_SELECT 4
`define FDG_CTRL_FDC_EN 5
`define FDG_CTRL_DRIVE1 6
`define FDG_CTRL_DRIVE2 7
`define FDG_CTRL_RESET 8'h00

// ===========================================================
// status register fields
`define FDG_STAT_CHANGE 0
`define FDG_STAT_END_CNT 1
`define FDG_STAT_TWO_SIDED 2
`define FDG_STAT_DRIVE_ID 3
`define FDG_STAT_DATA_REQ 4

// ===========================================================
// interrupt bits
`define FDG_IRQ_END_CNT 0
`define FDG_IRQ_DISK 1
`define FDG_IRQ_CHANGE 2
`define FDG_IRQ_W 3

// ===========================================================
// timing
`define FDG_CLK_HZ 25000000
`define FDG_CLK_NS_X10 400
`define FDG_PRECOMP_NS_X10 1875
`define FDG_PULSE_NS_X10 1875
`define FDG_HEAD_LOAD_MS 40
// shift and width: least time, rounded up
`define FDG_PRECOMP_CYC \
  ((`FDG_PRECOMP_NS_X10 + `FDG_CLK_NS_X10 - 1) / `FDG_CLK_NS_X10)
`define FDG_PULSE_CYC \
  ((`FDG_PULSE_NS_X10 + `FDG_CLK_NS_X10 - 1) / `FDG_CLK_NS_X10)
`define FDG_HEAD_LOAD_CYC (`FDG_CLK_HZ / 1000 * `FDG_HEAD_LOAD_MS)

`endif

// >>> hdl/fdg_pkg.sv
// types for the floppy controller glue block
package fdg_pkg;

  // ===========================================================
  // write path state
  typedef enum logic [1:0]
  {
    FDG_W_IDLE,
    FDG_W_DELAY,
    FDG_W_PULSE
  } fdg_wstate_type;

endpackage

// >>> hdl/fdg_wr_if.sv
// write path signals, glue to precompensator
`timescale 1ns/1ps
interface fdg_wr_if;
  logic data_pulse;
  logic early;
  logic late;
  logic precomp_enable_bit;
  logic wr_data;

  modport glue
  (
    output data_pulse,
    output early,
    output late,
    output precomp_enable_bit,
    input wr_data
  );

  modport comp
  (
    input data_pulse,
    input early,
    input late,
    input precomp_enable_bit,
    output wr_data
  );
endinterface

// >>> hdl/fdg_precomp.sv
// write precompensation and write pulse shaper
`timescale 1ns/1ps
`include "fdg_consts.svh"
module fdg_precomp
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  fdg_wr_if.comp wr
);

  localparam int SHIFT = `FDG_PRECOMP_CYC;
  localparam int WIDTH = `FDG_PULSE_CYC;
  localparam logic [3:0] SHIFT_C = 4'(SHIFT);
  localparam logic [3:0] WIDTH_C = 4'(WIDTH);

  fdg_pkg::fdg_wstate_type state;
  logic [3:0] count;
  logic precomp_disable_n;
  logic pulse;

  // ===========================================================
  // precomp applies only when enabled
  assign precomp_disable_n = wr.precomp_enable_bit;

  // ===========================================================
  // nominal pulses wait one shift; early none; late two
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      state <= fdg_pkg::FDG_W_IDLE;
      count <= 4'h0;
    end
    else
    begin
      case (state)
        fdg_pkg::FDG_W_IDLE:
        begin
          if (wr.data_pulse)
          begin
            if (precomp_disable_n && wr.early)
            begin
              state <= fdg_pkg::FDG_W_PULSE;
              count <= WIDTH_C;
            end
            else if (precomp_disable_n && wr.late)
            begin
              state <= fdg_pkg::FDG_W_DELAY;
              count <= SHIFT_C + SHIFT_C;
            end
            else
            begin
              state <= fdg_pkg::FDG_W_DELAY;
              count <= SHIFT_C;
            end
          end
        end
        fdg_pkg::FDG_W_DELAY:
        begin
          if (count == 4'h1)
          begin
            state <= fdg_pkg::FDG_W_PULSE;
            count <= WIDTH_C;
          end
          else
          begin
            count <= count - 4'h1;
          end
        end
        fdg_pkg::FDG_W_PULSE:
        begin
          if (count == 4'h1)
          begin
            state <= fdg_pkg::FDG_W_IDLE;
          end
          count <= count - 4'h1;
        end
        default:
        begin
          state <= fdg_pkg::FDG_W_IDLE;
        end
      endcase
    end
  end

  // ===========================================================
  // registered output; one clock of placement jitter at most
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      pulse <= 1'b0;
    end
    else
    begin
      pulse <= (state == fdg_pkg::FDG_W_PULSE);
    end
  end

  assign wr.wr_data = pulse;

endmodule // fdg_precomp

// >>> hdl/fdg_separator.sv
// read data synchroniser and data separator state machine
`timescale 1ns/1ps
`include "fdg_consts.svh"
module fdg_separator
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic raw_read_i,
  input wire logic separator_enable_i,
  input wire logic double_density_select_i,
  output logic synced_read_data_n_o,
  output logic data_window_o
);

  logic [2:0] sync;
  logic seen;
  logic edge_hit;
  logic [4:0] sep_state;

  // ===========================================================
  // three stages; second and third must agree for an edge
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      sync <= 3'h0;
      seen <= 1'b0;
    end
    else
    begin
      sync <= {sync[1:0], raw_read_i};
      if (sync[2] == sync[1])
      begin
        seen <= sync[2];
      end
    end
  end

  assign edge_hit = (sync[2] == sync[1]) && sync[2] && !seen;

  // ===========================================================
  // separator works on the complemented synchronised data
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      synced_read_data_n_o <= 1'b1;
    end
    else
    begin
      synced_read_data_n_o <= !(sync[2] && sync[1]);
    end
  end

  // ===========================================================
  // free running phase counter; no edge recentres the window, as edge_hit is never set while synced_read_data_n_o is low
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i || !separator_enable_i)
    begin
      sep_state <= 5'h00;
    end
    else if (!synced_read_data_n_o && edge_hit)
    begin
      sep_state <= {sep_state[4], 4'h8};
    end
    else if (double_density_select_i)
    begin
      sep_state <= sep_state + 5'h02;
    end
    else
    begin
      sep_state <= sep_state + 5'h01;
    end
  end

  assign data_window_o = sep_state[4];

endmodule // fdg_separator

// >>> hdl/fdg_glue.sv
// floppy controller glue: waits, latches, registers, drive pins
//
// The address map and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
`include "fdg_consts.svh"
module fdg_glue
#(
  parameter int HEAD_LOAD_CYC = `FDG_HEAD_LOAD_CYC
)
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic board_reset_n_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  // processor and dma side
  input wire logic cpu_fdc_access_i,
  input wire logic dma_slave_access_i,
  output logic processor_ready_wait_o,
  input wire logic fdc_data_request_i,
  input wire logic dma_ack_i,
  input wire logic dma_terminal_count_i,
  output logic dma_request_o,
  input wire logic disk_interrupt_request_i,
  // controller chip side
  input wire logic fdc_write_pulse_i,
  input wire logic fdc_early_i,
  input wire logic fdc_late_i,
  input wire logic inner_track_indicator_i,
  input wire logic head_load_i,
  output logic head_engaged_o,
  output logic synced_read_data_n_o,
  output logic data_window_o,
  // drive cable
  input wire logic drive_read_data_i,
  input wire logic drive_two_sided_i,
  input wire logic drive_id_i,
  input wire logic drive_change_i,
  output logic drive_write_data_o,
  output logic side_select_o,
  output logic drive1_select_o,
  output logic drive2_select_o,
  output logic double_density_select_o,
  output logic alt_mode_o,
  output logic fdc_enable_o
);

  // ===========================================================
  // register decode helpers
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  logic [7:0] ctrl;
  logic [`FDG_IRQ_W-1:0] irq_stat;
  logic [`FDG_IRQ_W-1:0] irq_mask;
  logic [`FDG_IRQ_W-1:0] irq_event;
  logic disk_data_request_latch;
  logic dma_terminal_count_latch;
  logic wb_req;
  logic wb_wr;
  logic [31:0] next_rdata;
  logic [2:0] sync_two;
  logic [2:0] sync_id;
  logic [2:0] sync_chg;
  logic two_sided;
  logic drive_id;
  logic disk_change;
  logic chg_prev;
  logic irq_prev;
  logic wait_done;
  logic [31:0] head_count;
  logic separator_enable;

  // ===========================================================
  // wishbone: one-cycle answer, ack dropped next cycle
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      wb_ack_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= wb_req;
    end
  end

  always_comb
  begin
    next_rdata = 32'h00000000;
    if (hit(wb_adr_i, `FDG_OFS_CTRL))
    begin
      next_rdata[7:0] = ctrl;
    end
    else if (hit(wb_adr_i, `FDG_OFS_STAT))
    begin
      next_rdata[`FDG_STAT_CHANGE] = disk_change;
      next_rdata[`FDG_STAT_END_CNT] = dma_terminal_count_latch;
      next_rdata[`FDG_STAT_TWO_SIDED] = two_sided;
      next_rdata[`FDG_STAT_DRIVE_ID] = drive_id;
      next_rdata[`FDG_STAT_DATA_REQ] = disk_data_request_latch;
    end
    else if (hit(wb_adr_i, `FDG_OFS_IRQ_STAT))
    begin
      next_rdata[`FDG_IRQ_W-1:0] = irq_stat;
    end
    else if (hit(wb_adr_i, `FDG_OFS_IRQ_MASK))
    begin
      next_rdata[`FDG_IRQ_W-1:0] = irq_mask;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      wb_dat_o <= 32'h00000000;
    end
    else if (wb_req)
    begin
      wb_dat_o <= next_rdata;
    end
  end

  // ===========================================================
  // control register
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      ctrl <= `FDG_CTRL_RESET;
    end
    else if (wb_wr && hit(wb_adr_i, `FDG_OFS_CTRL))
    begin
      ctrl <= wb_dat_i[7:0];
    end
  end

  assign side_select_o = ctrl[`FDG_CTRL_SIDE];
  assign drive1_select_o = ctrl[`FDG_CTRL_DRIVE1];
  assign drive2_select_o = ctrl[`FDG_CTRL_DRIVE2];
  assign double_density_select_o = ctrl[`FDG_CTRL_DOUBLE_DENSITY_SELECT];
  assign alt_mode_o = ctrl[`FDG_CTRL_ALT_MODE];
  assign fdc_enable_o = ctrl[`FDG_CTRL_FDC_EN];

  // ===========================================================
  // interrupt status and mask; a new event beats the clear
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      irq_mask <= 3'h0;
    end
    else if (wb_wr && hit(wb_adr_i, `FDG_OFS_IRQ_MASK))
    begin
      irq_mask <= wb_dat_i[`FDG_IRQ_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      irq_prev <= 1'b0;
      chg_prev <= 1'b0;
    end
    else
    begin
      irq_prev <= disk_interrupt_request_i;
      chg_prev <= disk_change;
    end
  end

  assign irq_event[`FDG_IRQ_END_CNT] = dma_terminal_count_i;
  assign irq_event[`FDG_IRQ_DISK] = disk_interrupt_request_i && !irq_prev;
  assign irq_event[`FDG_IRQ_CHANGE] = disk_change && !chg_prev;

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      irq_stat <= 3'h0;
    end
    else if (wb_wr && hit(wb_adr_i, `FDG_OFS_IRQ_STAT))
    begin
      irq_stat <= (irq_stat & ~wb_dat_i[`FDG_IRQ_W-1:0]) | irq_event;
    end
    else
    begin
      irq_stat <= irq_stat | irq_event;
    end
  end

  assign irq_o = |(irq_stat & irq_mask);

  // ===========================================================
  // request and terminal-count latches; set wins over service
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i || !board_reset_n_i)
    begin
      disk_data_request_latch <= 1'b0;
    end
    else if (fdc_data_request_i)
    begin
      disk_data_request_latch <= 1'b1;
    end
    else if (dma_ack_i)
    begin
      disk_data_request_latch <= 1'b0;
    end
  end

  assign dma_request_o = disk_data_request_latch;

  // cleared by board reset or a status read
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i || !board_reset_n_i)
    begin
      dma_terminal_count_latch <= 1'b0;
    end
    else if (dma_terminal_count_i && dma_ack_i)
    begin
      dma_terminal_count_latch <= 1'b1;
    end
    else if (wb_req && !wb_we_i && hit(wb_adr_i, `FDG_OFS_STAT))
    begin
      dma_terminal_count_latch <= 1'b0;
    end
  end

  // ===========================================================
  // wait state: ready low for the first cycle of each dma access, and of each fdc access with wait-enable set
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      wait_done <= 1'b0;
    end
    else
    begin
      wait_done <= cpu_fdc_access_i || dma_slave_access_i;
    end
  end

  // high means ready; wait-enable bit gates the fdc stretch
  assign processor_ready_wait_o =
    !((cpu_fdc_access_i && ctrl[`FDG_CTRL_WAIT_EN] && !wait_done)
      || (dma_slave_access_i && !wait_done));

  // ===========================================================
  // drive status pins, three-stage synchronised
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      sync_two <= 3'h0;
      sync_id <= 3'h0;
      sync_chg <= 3'h0;
      two_sided <= 1'b0;
      drive_id <= 1'b0;
      disk_change <= 1'b0;
    end
    else
    begin
      sync_two <= {sync_two[1:0], drive_two_sided_i};
      sync_id <= {sync_id[1:0], drive_id_i};
      sync_chg <= {sync_chg[1:0], drive_change_i};
      if (sync_two[2] == sync_two[1])
      begin
        two_sided <= sync_two[2];
      end
      if (sync_id[2] == sync_id[1])
      begin
        drive_id <= sync_id[2];
      end
      if (sync_chg[2] == sync_chg[1])
      begin
        disk_change <= sync_chg[2];
      end
    end
  end

  // ===========================================================
  // head load delay
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i || !head_load_i)
    begin
      head_count <= 32'h00000000;
      head_engaged_o <= 1'b0;
    end
    else if (head_count == 32'(HEAD_LOAD_CYC - 1))
    begin
      head_engaged_o <= 1'b1;
    end
    else
    begin
      head_count <= head_count + 32'h00000001;
    end
  end

  // ===========================================================
  // write and read paths
  fdg_wr_if wr_bus ();

  assign wr_bus.data_pulse = fdc_write_pulse_i;
  assign wr_bus.early = fdc_early_i;
  assign wr_bus.late = fdc_late_i;
  assign wr_bus.precomp_enable_bit = ctrl[`FDG_CTRL_PRECOMP];
  assign drive_write_data_o = wr_bus.wr_data;

  fdg_precomp u_precomp
  (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .wr(wr_bus)
  );

  // separator runs while the fdc is enabled
  assign separator_enable = ctrl[`FDG_CTRL_FDC_EN];

  fdg_separator u_sep
  (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .raw_read_i(drive_read_data_i),
    .separator_enable_i(separator_enable),
    .double_density_select_i(ctrl[`FDG_CTRL_DOUBLE_DENSITY_SELECT]),
    .synced_read_data_n_o(synced_read_data_n_o),
    .data_window_o(data_window_o)
  );

endmodule // fdg_glue

// >>> bench/fdg_glue_chk.sv
// port assertions for the glue
`timescale 1ns/1ps
module fdg_glue_chk
#(
  parameter int HEAD_LOAD_CYC = 20
)
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic board_reset_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic cpu_fdc_access_i,
  input wire logic dma_slave_access_i,
  input wire logic processor_ready_wait_o,
  input wire logic fdc_data_request_i,
  input wire logic dma_ack_i,
  input wire logic dma_request_o,
  input wire logic head_load_i,
  input wire logic head_engaged_o,
  input wire logic drive_read_data_i,
  input wire logic synced_read_data_n_o,
  input wire logic drive_write_data_o
);
  // ===========================================================
  // saturating head load count
  logic [31:0] hl_cnt;
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i || !head_load_i)
      hl_cnt <= 32'h0;
    else if (hl_cnt < 32'(HEAD_LOAD_CYC + 4))
      hl_cnt <= hl_cnt + 32'h1;
  end

  // ===========================================================
  // properties
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence one_wait_s;
    !processor_ready_wait_o ##1 processor_ready_wait_o;
  endsequence

  sequence write_pulse_s;
    drive_write_data_o [*5] ##1 !drive_write_data_o;
  endsequence

  ack_reply_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  ack_once_a:
    assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  cpu_wait_a:
    assert property ($past(cpu_fdc_access_i) && cpu_fdc_access_i &&
      !dma_slave_access_i |-> processor_ready_wait_o)
    else $error("fdc wait too long");
  dma_wait_a:
    assert property ($rose(dma_slave_access_i) |-> one_wait_s)
    else $error("dma wait wrong");
  req_clear_a:
    assert property (!board_reset_n_i ##1 !board_reset_n_i |-> !dma_request_o)
    else $error("req not cleared");
  req_set_a:
    assert property (fdc_data_request_i && board_reset_n_i
      |=> ##[0:1] dma_request_o)
    else $error("req not set");
  req_hold_a:
    assert property (dma_request_o && !dma_ack_i && board_reset_n_i
      |=> dma_request_o)
    else $error("req dropped");
  pulse_width_a:
    assert property ($rose(drive_write_data_o) |-> write_pulse_s)
    else $error("bad pulse width");
  head_wait_a:
    assert property (hl_cnt < 32'(HEAD_LOAD_CYC) |-> !head_engaged_o)
    else $error("head early");
  head_on_a:
    assert property (hl_cnt > 32'(HEAD_LOAD_CYC + 2) |-> head_engaged_o)
    else $error("head late");
  read_idle_a:
    assert property (!drive_read_data_i [*8] |-> synced_read_data_n_o)
    else $error("read idle wrong");
  read_sync_a:
    assert property ($rose(drive_read_data_i)
      |-> ##[1:5] !synced_read_data_n_o)
    else $error("read pulse lost");
endmodule // fdg_glue_chk

bind fdg_glue fdg_glue_chk #(.HEAD_LOAD_CYC(HEAD_LOAD_CYC)) i_fdg_glue_chk
(
  .ref_clk_i, .rst_n_i, .board_reset_n_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .cpu_fdc_access_i, .dma_slave_access_i, .processor_ready_wait_o,
  .fdc_data_request_i, .dma_ack_i, .dma_request_o, .head_load_i,
  .head_engaged_o, .drive_read_data_i, .synced_read_data_n_o,
  .drive_write_data_o
);

// >>> bench/fdg_drive_model.sv
// floppy drive model
`timescale 1ns/1ps
module fdg_drive_model
(
  input wire logic ref_clk_i,
  input wire logic write_data_i,
  output logic read_data_o,
  output logic two_sided_o,
  output logic drive_id_o,
  output logic change_o
);
  int n_writes = 0;
  int rd_left = 0;
  logic wd_q = 1'b0;

  // ===========================================================
  // read pulses held long enough for a three stage sync
  assign read_data_o = (rd_left > 0);
  always @(posedge ref_clk_i)
  begin
    wd_q <= write_data_i;
    if (write_data_i && !wd_q)
      n_writes <= n_writes + 1;
    if (rd_left > 0)
      rd_left <= rd_left - 1;
  end

  initial
  begin
    two_sided_o = 1'b0;
    drive_id_o = 1'b0;
    change_o = 1'b0;
  end

  task automatic start_bit();
    rd_left <= 4;
  endtask

  task automatic set_pins(input logic two, input logic id, input logic chg);
    two_sided_o <= two;
    drive_id_o <= id;
    change_o <= chg;
  endtask
endmodule // fdg_drive_model

// >>> bench/testbench.sv
// self-checking bench for the glue
`timescale 1ns/1ps
`include "fdg_consts.svh"
`define CHECK_EQ(nm, e, g) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); \
    end \
  end
module testbench;
  // short head load delay keeps the run brief
  localparam int HLC = 20;
  int n_errors = 0;
  int cmp_count = 0;
  int dn, de, dl, d, w, n;
  logic ref_clk_i, rst_n_i, board_reset_n_i, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic wb_ack_o, irq_o, cpu_fdc_access_i, dma_slave_access_i;
  logic processor_ready_wait_o, fdc_data_request_i, dma_ack_i;
  logic dma_terminal_count_i, dma_request_o, disk_interrupt_request_i;
  logic fdc_write_pulse_i, fdc_early_i, fdc_late_i, inner_track_indicator_i;
  logic head_load_i, head_engaged_o, synced_read_data_n_o, data_window_o;
  logic drive_read_data_i, drive_two_sided_i, drive_id_i, drive_change_i;
  logic drive_write_data_o, side_select_o, drive1_select_o, drive2_select_o;
  logic double_density_select_o, alt_mode_o, fdc_enable_o;

  fdg_glue #(.HEAD_LOAD_CYC(HLC)) i_fdg_glue
  (
    .ref_clk_i, .rst_n_i, .board_reset_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o,
    .cpu_fdc_access_i, .dma_slave_access_i, .processor_ready_wait_o,
    .fdc_data_request_i, .dma_ack_i, .dma_terminal_count_i, .dma_request_o,
    .disk_interrupt_request_i, .fdc_write_pulse_i, .fdc_early_i,
    .fdc_late_i, .inner_track_indicator_i, .head_load_i, .head_engaged_o,
    .synced_read_data_n_o, .data_window_o, .drive_read_data_i,
    .drive_two_sided_i, .drive_id_i, .drive_change_i, .drive_write_data_o,
    .side_select_o, .drive1_select_o, .drive2_select_o,
    .double_density_select_o, .alt_mode_o, .fdc_enable_o
  );

  fdg_drive_model i_drv
  (
    .ref_clk_i(ref_clk_i), .write_data_i(drive_write_data_o),
    .read_data_o(drive_read_data_i), .two_sided_o(drive_two_sided_i),
    .drive_id_o(drive_id_i), .change_o(drive_change_i)
  );

  // ===========================================================
  // clock, watchdog, verdict
  initial
  begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    n_errors++;
    give_verdict();
  end

  task automatic give_verdict();
    if (n_errors == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk_i);
  endtask

  // ===========================================================
  // classic bus cycle
  task automatic wb_xfer(input logic we, input logic [7:0] a,
    input logic [31:0] dat);
    int t;
    t = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hF;
    @(posedge ref_clk_i);
    while (wb_ack_o !== 1'b1 && t < 16)
    begin
      @(posedge ref_clk_i);
      t++;
    end
    if (t == 16)
      n_errors++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  task automatic access(input logic dma, input logic first);
    cpu_fdc_access_i <= !dma;
    dma_slave_access_i <= dma;
    @(negedge ref_clk_i);
    `CHECK_EQ("ready first", first, processor_ready_wait_o)
    @(negedge ref_clk_i);
    `CHECK_EQ("ready next", 1'b1, processor_ready_wait_o)
    @(posedge ref_clk_i);
    cpu_fdc_access_i <= 1'b0;
    dma_slave_access_i <= 1'b0;
    tick(1);
  endtask

  // pulse delay and width
  task automatic wr_pulse(input logic e, input logic l, output int dly);
    fdc_write_pulse_i <= 1'b1;
    fdc_early_i <= e;
    fdc_late_i <= l;
    @(posedge ref_clk_i);
    fdc_write_pulse_i <= 1'b0;
    dly = 0;
    w = 0;
    while (drive_write_data_o !== 1'b1 && dly < 30)
    begin
      @(posedge ref_clk_i);
      dly++;
    end
    while (drive_write_data_o === 1'b1 && w < 30)
    begin
      @(posedge ref_clk_i);
      w++;
    end
    `CHECK_EQ("pulse width", 5, w)
    tick(20);
  endtask

  // ===========================================================
  // tests
  initial
  begin
    {rst_n_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i,
      cpu_fdc_access_i, dma_slave_access_i, fdc_data_request_i, dma_ack_i,
      dma_terminal_count_i, disk_interrupt_request_i, fdc_write_pulse_i,
      fdc_early_i, fdc_late_i, inner_track_indicator_i, head_load_i} = '0;
    board_reset_n_i = 1'b1;
    tick(8);
    rst_n_i <= 1'b1;
    tick(1);
    `CHECK_EQ("reset pins", 4'hC, {processor_ready_wait_o,
      synced_read_data_n_o, dma_request_o, head_engaged_o})
    wb_xfer(1'b0, `FDG_OFS_CTRL, 32'h0);
    `CHECK_EQ("ctrl reset", 32'h0, rd)
    wb_xfer(1'b1, 8'h40, 32'hFF);
    wb_xfer(1'b0, 8'h40, 32'h0);
    `CHECK_EQ("unmapped", 32'h0, rd)
    for (int b = 2; b < 8; b++)
    begin
      wb_xfer(1'b1, `FDG_OFS_CTRL, 32'h1 << b);
      `CHECK_EQ("ctrl pins", 8'h1 << b, {drive2_select_o,
        drive1_select_o, fdc_enable_o, double_density_select_o,
        alt_mode_o, side_select_o, 2'b00})
    end
    wb_xfer(1'b0, `FDG_OFS_CTRL, 32'h0);
    `CHECK_EQ("ctrl read", 32'h80, rd)
    i_drv.set_pins(1'b1, 1'b1, 1'b0);
    tick(8);
    wb_xfer(1'b0, `FDG_OFS_STAT, 32'h0);
    `CHECK_EQ("status pins", 32'hC, rd & 32'hD)
    wb_xfer(1'b1, `FDG_OFS_CTRL, 32'h1);
    access(1'b0, 1'b0);
    access(1'b1, 1'b0);
    wb_xfer(1'b1, `FDG_OFS_CTRL, 32'h0);
    access(1'b0, 1'b1);
    fdc_data_request_i <= 1'b1;
    tick(1);
    fdc_data_request_i <= 1'b0;
    tick(4);
    `CHECK_EQ("request held", 1'b1, dma_request_o)
    wb_xfer(1'b0, `FDG_OFS_STAT, 32'h0);
    `CHECK_EQ("request status", 1'b1, rd[`FDG_STAT_DATA_REQ])
    dma_ack_i <= 1'b1;
    tick(1);
    dma_ack_i <= 1'b0;
    tick(2);
    `CHECK_EQ("request served", 1'b0, dma_request_o)
    {fdc_data_request_i, dma_terminal_count_i, dma_ack_i} <= 3'b111;
    tick(1);
    {fdc_data_request_i, dma_terminal_count_i, dma_ack_i} <= 3'b000;
    tick(2);
    board_reset_n_i <= 1'b0;
    tick(2);
    board_reset_n_i <= 1'b1;
    tick(1);
    `CHECK_EQ("board reset req", 1'b0, dma_request_o)
    wb_xfer(1'b0, `FDG_OFS_STAT, 32'h0);
    `CHECK_EQ("board reset end", 1'b0, rd[`FDG_STAT_END_CNT])
    wb_xfer(1'b1, `FDG_OFS_IRQ_STAT, 32'h7);
    wb_xfer(1'b1, `FDG_OFS_IRQ_MASK, 32'h7);
    {dma_terminal_count_i, dma_ack_i} <= 2'b11;
    tick(1);
    {dma_terminal_count_i, dma_ack_i} <= 2'b00;
    tick(2);
    `CHECK_EQ("count irq", 1'b1, irq_o)
    wb_xfer(1'b0, `FDG_OFS_STAT, 32'h0);
    `CHECK_EQ("end count", 1'b1, rd[`FDG_STAT_END_CNT])
    wb_xfer(1'b0, `FDG_OFS_STAT, 32'h0);
    `CHECK_EQ("end count read", 1'b0, rd[`FDG_STAT_END_CNT])
    wb_xfer(1'b1, `FDG_OFS_IRQ_STAT, 32'h1);
    `CHECK_EQ("irq cleared", 1'b0, irq_o)
    disk_interrupt_request_i <= 1'b1;
    i_drv.set_pins(1'b0, 1'b0, 1'b1);
    tick(8);
    disk_interrupt_request_i <= 1'b0;
    wb_xfer(1'b0, `FDG_OFS_IRQ_STAT, 32'h0);
    `CHECK_EQ("irq status", 32'h6, rd)
    wb_xfer(1'b1, `FDG_OFS_IRQ_MASK, 32'h0);
    `CHECK_EQ("irq masked", 1'b0, irq_o)
    wb_xfer(1'b0, `FDG_OFS_STAT, 32'h0);
    `CHECK_EQ("change pin", 32'h1, rd & 32'hD)
    wb_xfer(1'b1, `FDG_OFS_IRQ_STAT, 32'h6);
    wb_xfer(1'b0, `FDG_OFS_IRQ_STAT, 32'h0);
    `CHECK_EQ("irq status clear", 32'h0, rd)
    // precomp on, then off
    wb_xfer(1'b1, `FDG_OFS_CTRL, 32'h2);
    wr_pulse(1'b0, 1'b0, dn);
    wr_pulse(1'b1, 1'b0, de);
    wr_pulse(1'b0, 1'b1, dl);
    `CHECK_EQ("early shift", 1'b1, (dn - de) inside {[3:6]})
    `CHECK_EQ("late shift", 1'b1, (dl - dn) inside {[3:6]})
    wb_xfer(1'b1, `FDG_OFS_CTRL, 32'h0);
    wr_pulse(1'b1, 1'b0, d);
    `CHECK_EQ("no early", 1'b1, (d - dn) inside {[-1:1]})
    wr_pulse(1'b0, 1'b1, d);
    `CHECK_EQ("no late", 1'b1, (d - dn) inside {[-1:1]})
    `CHECK_EQ("pulses sent", 5, i_drv.n_writes)
    head_load_i <= 1'b1;
    n = 0;
    while (head_engaged_o !== 1'b1 && n < 100)
    begin
      @(posedge ref_clk_i);
      n++;
    end
    `CHECK_EQ("head delay", 1'b1, n inside {[HLC:HLC + 2]})
    head_load_i <= 1'b0;
    tick(2);
    `CHECK_EQ("head drop", 1'b0, head_engaged_o)
    wb_xfer(1'b1, `FDG_OFS_CTRL, 32'h20);
    i_drv.start_bit();
    n = 0;
    repeat (7)
    begin
      @(posedge ref_clk_i);
      if (synced_read_data_n_o === 1'b0)
        n++;
    end
    `CHECK_EQ("read sync", 1'b1, n > 0)
    tick(10);
    `CHECK_EQ("read idle", 1'b1, synced_read_data_n_o)
    give_verdict();
  end
endmodule // testbench
